//--- hdl/exc_lowpower_defs.vh
// Register offsets, field positions, reset values and timing counts for the exception and low-power controller.
`ifndef EXC_LOWPOWER_DEFS_VH
`define EXC_LOWPOWER_DEFS_VH
`define ADDR_BREAK_STATUS      16'hFE00
`define ADDR_RESET_SOURCE      16'hFE01
`define ADDR_BREAK_FLAG_CTRL   16'hFE03
`define ADDR_LOWPOWER_OPTIONS  16'hFE04
`define BIT_BREAK_EXIT_LP      1
`define BIT_BREAK_CLEAR_EN     7
`define BIT_RST_LVI            1
`define BIT_RST_ILAD           3
`define BIT_RST_ILOP           4
`define BIT_RST_WDOG           5
`define BIT_RST_PIN            6
`define BIT_RST_POR            7
`define BIT_OPT_SHORT_REC      0
`define BIT_OPT_WDOG_DIS       1
`define RESET_SOURCE_POR       8'h80
`define OPTIONS_RESET          8'h00
`define STOP_REC_LONG_CYC      13'h1000
`define STOP_REC_SHORT_CYC     13'h0020
`define NUM_IRQ                8
`endif

//--- hdl/exc_lowpower_ctrl.v
// Exception arbitration, break handling and wait/stop low-power control.
`timescale 1ns/100ps
`include "exc_lowpower_defs.vh"
module exc_lowpower_ctrl (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Register port
  input  wire [15:0] reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  // Reset cause inputs, one-cycle pulses from same-domain logic
  input  wire        rst_cause_por,
  input  wire        rst_cause_pin,
  input  wire        rst_cause_wdog,
  input  wire        rst_cause_ilop,
  input  wire        rst_cause_ilad,
  input  wire        rst_cause_lvi,
  // Processor core
  input  wire        instr_done,
  input  wire        irq_mask,
  input  wire        trap_exec,
  input  wire        wait_exec,
  input  wire        stop_exec,
  input  wire        stack_done,
  output reg         take_exception,
  output reg  [3:0]  vector_sel,
  output reg         stack_pc_minus_one,
  output reg         clear_irq_mask,
  output reg         core_reset,
  // Interrupt sources and break module, asynchronous
  input  wire [7:0]  irq_req,
  input  wire [7:0]  irq_enable,
  input  wire        break_req,
  // Clock gating and break protection
  output reg         core_clk_en,
  output reg         periph_clk_en,
  output reg         base_clock_out_en,
  output reg         crystal_clock_en,
  output reg         watchdog_run,
  output reg         in_break,
  output reg         flag_clear_allow
);

  localparam ST_RUN     = 5'h01;
  localparam ST_WAIT    = 5'h02;
  localparam ST_STOP    = 5'h04;
  localparam ST_RECOVER = 5'h08;
  localparam ST_SERVICE = 5'h10;

  localparam [3:0] VEC_TRAP = 4'hF;

  reg [4:0]  state;
  reg [7:0]  irq_meta;
  reg [7:0]  irq_sync;
  reg        brk_meta;
  reg        brk_sync;
  reg [7:0]  break_status_reg;
  reg [7:0]  reset_source_reg;
  reg [7:0]  break_flag_control_reg;
  reg [7:0]  option_register;
  reg [12:0] sys_counter;
  reg        latched;
  reg [3:0]  latched_vec;
  reg [3:0]  next_vec;
  reg        next_any;
  reg        next_core_clk_en;
  reg        next_periph_clk_en;
  reg        next_base_clk_en;
  reg        next_crystal_clk_en;
  reg        next_watchdog_run;

  // Lowest index wins; a fixed order keeps arbitration a single cycle.
  function [3:0] prio_pick;
    input [7:0] req;
    integer k;
    begin
      prio_pick = 4'h0;
      for (k = `NUM_IRQ - 1; k >= 0; k = k - 1) begin
        if (req[k]) begin
          prio_pick = k[3:0];
        end
      end
    end
  endfunction

  // Address decode is shared by the write path and the read-clear.
  function addr_is;
    input [15:0] addr;
    input [15:0] target;
    begin
      addr_is = (addr == target);
    end
  endfunction

  // Break wins over a peripheral request when both end a low-power mode.
  function [3:0] wake_vec;
    input       brk;
    input [3:0] irq_vec;
    begin
      wake_vec = brk ? VEC_TRAP : irq_vec;
    end
  endfunction

  wire [7:0]  irq_live   = irq_sync & irq_enable;
  wire        wake_any   = (|irq_live) | brk_sync;
  wire        any_reset  = rst_cause_por | rst_cause_pin | rst_cause_wdog |
                           rst_cause_ilop | rst_cause_ilad | rst_cause_lvi;
  wire        short_rec  = option_register[`BIT_OPT_SHORT_REC];
  wire [12:0] rec_target = short_rec ? `STOP_REC_SHORT_CYC : `STOP_REC_LONG_CYC;
  wire        wr_break   = reg_wr && addr_is(reg_addr, `ADDR_BREAK_STATUS);

  always @* begin
    next_any = |irq_live;
    next_vec = prio_pick(irq_live);
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      irq_meta <= 8'h00;
      irq_sync <= 8'h00;
      brk_meta <= 1'b0;
      brk_sync <= 1'b0;
    end else begin
      irq_meta <= irq_req;
      irq_sync <= irq_meta;
      brk_meta <= break_req;
      brk_sync <= brk_meta;
    end
  end

  // Read data return to zero outside the read slot, so several slaves may be ORed.
  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_BREAK_STATUS:     reg_rdata <= break_status_reg;
        `ADDR_RESET_SOURCE:     reg_rdata <= reset_source_reg;
        `ADDR_BREAK_FLAG_CTRL:  reg_rdata <= break_flag_control_reg;
        `ADDR_LOWPOWER_OPTIONS: reg_rdata <= option_register;
        default:                reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Only the option bits are kept; the other bits of each register read zero.
  always @(posedge clk) begin
    if (sys_rst) begin
      break_flag_control_reg <= 8'h00;
      option_register        <= `OPTIONS_RESET;
    end else if (reg_wr) begin
      if (addr_is(reg_addr, `ADDR_BREAK_FLAG_CTRL)) begin
        break_flag_control_reg <= {reg_wdata[`BIT_BREAK_CLEAR_EN], 7'h00};
      end
      if (addr_is(reg_addr, `ADDR_LOWPOWER_OPTIONS)) begin
        option_register <= {6'h00, reg_wdata[1:0]};
      end
    end
  end

  // A new cause in the read cycle wins over the read-clear.
  always @(posedge clk) begin
    if (rst_cause_por) begin
      reset_source_reg <= `RESET_SOURCE_POR;
    end else if (any_reset) begin
      reset_source_reg <= {1'b0, rst_cause_pin, rst_cause_wdog, rst_cause_ilop,
                           rst_cause_ilad, 1'b0, rst_cause_lvi, 1'b0};
    end else if (sys_rst) begin
      reset_source_reg <= reset_source_reg;
    end else if (reg_rd && addr_is(reg_addr, `ADDR_RESET_SOURCE)) begin
      reset_source_reg <= 8'h00;
    end
  end

  // The break set is tested before the software clear, so a break in the clear cycle wins.
  always @(posedge clk) begin
    if (sys_rst || any_reset) begin
      break_status_reg <= 8'h00;
    end else if (brk_sync && (state == ST_WAIT || state == ST_STOP)) begin
      break_status_reg[`BIT_BREAK_EXIT_LP] <= 1'b1;
    end else if (wr_break && !reg_wdata[`BIT_BREAK_EXIT_LP]) begin
      break_status_reg[`BIT_BREAK_EXIT_LP] <= 1'b0;
    end
  end

  // The counter is reused for recovery so stop costs no extra timer.
  always @(posedge clk) begin
    if (sys_rst || state == ST_STOP) begin
      sys_counter <= 13'h0000;
    end else begin
      sys_counter <= sys_counter + 13'h0001;
    end
  end

  // Every reset cause returns to run, so a fault can never leave the core parked in stop.
  always @(posedge clk) begin
    if (sys_rst || any_reset) begin
      state              <= ST_RUN;
      latched            <= 1'b0;
      latched_vec        <= 4'h0;
      take_exception     <= 1'b0;
      vector_sel         <= 4'h0;
      stack_pc_minus_one <= 1'b0;
      clear_irq_mask     <= 1'b0;
      core_reset         <= any_reset;
      in_break           <= 1'b0;
    end else begin
      take_exception <= 1'b0;
      clear_irq_mask <= 1'b0;
      core_reset     <= 1'b0;
      if (latched && irq_mask && state != ST_SERVICE) begin
        latched <= latched;
      end else if (!irq_mask || state == ST_SERVICE) begin
        latched <= latched && state == ST_SERVICE;
      end
      case (state)
        ST_RUN: begin
          if (instr_done) begin
            if (brk_sync) begin
              take_exception     <= 1'b1;
              vector_sel         <= VEC_TRAP;
              stack_pc_minus_one <= 1'b0;
              in_break           <= 1'b1;
              state              <= ST_SERVICE;
            end else if (trap_exec) begin
              take_exception     <= 1'b1;
              vector_sel         <= VEC_TRAP;
              stack_pc_minus_one <= 1'b0;
              state              <= ST_SERVICE;
            end else if (wait_exec) begin
              clear_irq_mask <= 1'b1;
              state          <= ST_WAIT;
            end else if (stop_exec) begin
              clear_irq_mask <= 1'b1;
              state          <= ST_STOP;
            end else if ((latched || next_any) && !irq_mask) begin
              take_exception     <= 1'b1;
              vector_sel         <= latched ? latched_vec : next_vec;
              stack_pc_minus_one <= 1'b1;
              latched            <= 1'b1;
              latched_vec        <= latched ? latched_vec : next_vec;
              state              <= ST_SERVICE;
            end
          end
        end
        ST_WAIT: begin
          if (wake_any) begin
            take_exception     <= 1'b1;
            vector_sel         <= wake_vec(brk_sync, next_vec);
            stack_pc_minus_one <= !brk_sync;
            in_break           <= brk_sync;
            state              <= ST_SERVICE;
          end
        end
        ST_STOP: begin
          if (wake_any) begin
            state <= ST_RECOVER;
          end
        end
        ST_RECOVER: begin
          if (sys_counter >= rec_target - 13'h0001) begin
            take_exception     <= 1'b1;
            vector_sel         <= wake_vec(brk_sync, next_vec);
            stack_pc_minus_one <= !brk_sync;
            in_break           <= brk_sync;
            state              <= ST_SERVICE;
          end
        end
        ST_SERVICE: begin
          if (stack_done) begin
            latched <= 1'b0;
            state   <= ST_RUN;
          end
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
      if (in_break && !brk_sync && state == ST_RUN) begin
        in_break <= 1'b0;
      end
    end
  end

  // Stop gates both clock outputs; recovery keeps peripherals off until stacking.
  always @* begin
    next_core_clk_en    = (state == ST_RUN) || (state == ST_SERVICE);
    next_periph_clk_en  = (state != ST_STOP) && (state != ST_RECOVER);
    next_base_clk_en    = (state != ST_STOP);
    next_crystal_clk_en = (state != ST_STOP);
    next_watchdog_run   = !option_register[`BIT_OPT_WDOG_DIS] && (state != ST_STOP);
  end

  // Flag-owning modules other than this one gate every clear step with flag_clear_allow, so the second
  // step of a two-step clear only lands once break ends or clearing is enabled.
  always @(posedge clk) begin
    if (sys_rst) begin
      core_clk_en       <= 1'b1;
      periph_clk_en     <= 1'b1;
      base_clock_out_en <= 1'b1;
      crystal_clock_en  <= 1'b1;
      watchdog_run      <= 1'b0;
      flag_clear_allow  <= 1'b1;
    end else begin
      core_clk_en       <= next_core_clk_en;
      periph_clk_en     <= next_periph_clk_en;
      base_clock_out_en <= next_base_clk_en;
      crystal_clock_en  <= next_crystal_clk_en;
      watchdog_run      <= next_watchdog_run;
      flag_clear_allow  <= !in_break || break_flag_control_reg[`BIT_BREAK_CLEAR_EN];
    end
  end

endmodule

//--- bench/core_model.sv
// Behavioural processor core: instruction completion, mask flag and stacking.
`timescale 1ns/100ps
module core_model #(
  parameter [3:0] STACK_CYC = 4'h3
) (
  // Clock and reset
  input  wire clk,
  input  wire sys_rst,
  // Controller side
  input  wire core_clk_en,
  input  wire take_exception,
  input  wire clear_irq_mask,
  input  wire return_from_interrupt_instruction,
  output wire instr_done,
  output reg  irq_mask,
  output reg  stack_done
);
  reg [3:0] cnt;
  // No instruction completes while stacking, so no request can land mid-entry.
  assign instr_done = core_clk_en && cnt == 4'h0 && !stack_done;
  always @(posedge clk) begin
    if (sys_rst) begin
      cnt <= 4'h0;
      irq_mask <= 1'b1;
      stack_done <= 1'b0;
    end else begin
      stack_done <= cnt == 4'h1;
      if (clear_irq_mask || return_from_interrupt_instruction)
        irq_mask <= 1'b0;
      if (take_exception) begin
        cnt <= STACK_CYC;
        irq_mask <= 1'b1;
      end else if (cnt != 4'h0)
        cnt <= cnt - 4'h1;
    end
  end
endmodule

//--- bench/sys_exc_properties.sv
// Port-level assertions for the exception and low-power controller.
`timescale 1ns/100ps
module sys_exc_checker (
  // Clock and reset
  input wire       clk,
  input wire       sys_rst,
  // Register port
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  // Core side
  input wire       rst_cause_por,
  input wire       instr_done,
  input wire [7:0] irq_enable,
  input wire       take_exception,
  input wire [3:0] vector_sel,
  input wire       stack_pc_minus_one,
  input wire       clear_irq_mask,
  input wire       core_reset,
  // Clock gating and break
  input wire       core_clk_en,
  input wire       periph_clk_en,
  input wire       base_clock_out_en,
  input wire       crystal_clock_en,
  input wire       in_break,
  input wire       flag_clear_allow
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  property p_vec_kind; take_exception |-> (vector_sel == 4'hF) == !stack_pc_minus_one; endproperty
  a_vec_kind: assert property (p_vec_kind) else $error("vector and stacked pc disagree");
  property p_irq_en; take_exception && stack_pc_minus_one |-> $past(irq_enable[vector_sel[2:0]]); endproperty
  a_irq_en: assert property (p_irq_en) else $error("disabled source taken");
  property p_after_instr; take_exception && stack_pc_minus_one |-> $past(instr_done) || !$past(core_clk_en); endproperty
  a_after_instr: assert property (p_after_instr) else $error("irq taken mid instruction");
  property p_reset_pulse; rst_cause_por |=> core_reset; endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset cause not forwarded");
  property p_mask_clear; $fell(core_clk_en) |-> $past(clear_irq_mask) or ##[0:2] clear_irq_mask; endproperty
  a_mask_clear: assert property (p_mask_clear) else $error("mask not cleared on low power");
  property p_stop_clocks; !crystal_clock_en |-> !base_clock_out_en && !core_clk_en && !periph_clk_en; endproperty
  a_stop_clocks: assert property (p_stop_clocks) else $error("clock left running in stop");
  property p_break_only; !$past(in_break) |-> flag_clear_allow; endproperty
  a_break_only: assert property (p_break_only) else $error("flags blocked outside break");
  c_trap: cover property (take_exception && !stack_pc_minus_one);
  c_stop: cover property (!crystal_clock_en);
  c_break: cover property (in_break && flag_clear_allow);
endmodule
bind exc_lowpower_ctrl sys_exc_checker i_chk (.*);

//--- bench/tb_sys_exception_lowpower_ctrl.sv
// Self-checking bench for the exception and low-power controller.
`timescale 1ns/100ps
module tb_sys_exception_lowpower_ctrl;
  reg        clk, sys_rst, reg_wr, reg_rd, return_from_interrupt_instruction, trap_exec, wait_exec, stop_exec, break_req;
  reg        rst_cause_por, rst_cause_wdog;
  reg [15:0] reg_addr;
  reg [7:0]  reg_wdata, irq_req, irq_enable;
  wire [7:0] reg_rdata;
  wire [3:0] vector_sel;
  wire       instr_done, irq_mask, stack_done, take_exception, stack_pc_minus_one, clear_irq_mask, core_reset;
  wire       core_clk_en, periph_clk_en, base_clock_out_en, crystal_clock_en, watchdog_run, in_break, flag_clear_allow;
  reg        rst_cause_pin, rst_cause_ilop, rst_cause_ilad, rst_cause_lvi;
  integer    num_errors, checked, n;
  exc_lowpower_ctrl i_dut (.*);
  core_model i_core (.*);
  always #5 clk = ~clk;
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chk_exc(input [3:0] vec, input spm1);
    chk({take_exception, stack_pc_minus_one, 2'h0, vector_sel}, {1'b1, spm1, 2'h0, vec});
  endtask
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [15:0] a, input [7:0] e);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
    end
  endtask
  // Order of c: power-on, pin, watchdog, illegal opcode, illegal address, low voltage.
  task pulse_cause(input [5:0] c);
    begin
      @(posedge clk);
      {rst_cause_por, rst_cause_pin, rst_cause_wdog, rst_cause_ilop, rst_cause_ilad, rst_cause_lvi} <= c;
      @(posedge clk);
      {rst_cause_por, rst_cause_pin, rst_cause_wdog, rst_cause_ilop, rst_cause_ilad, rst_cause_lvi} <= 6'h00;
      #1;
      chk({7'h0, core_reset}, 8'h01);
    end
  endtask
  task core_op(input [3:0] k);
    begin
      @(posedge clk);
      {return_from_interrupt_instruction, trap_exec, wait_exec, stop_exec} <= k;
      @(posedge clk);
      {return_from_interrupt_instruction, trap_exec, wait_exec, stop_exec} <= 4'h0;
    end
  endtask
  // Counts cycles until an exception pulse; n equals lim when none came.
  task wait_take(input integer lim);
    begin
      n = 0;
      #1;
      while (take_exception !== 1'b1 && n < lim) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
    end
  endtask
  task t_regs;
    begin
      pulse_cause(6'h20);
      rd(16'hFE01, 8'h80);
      rd(16'hFE01, 8'h00);
      pulse_cause(6'h08);
      rd(16'hFE01, 8'h20);
      pulse_cause(6'h10);
      rd(16'hFE01, 8'h40);
      pulse_cause(6'h04);
      rd(16'hFE01, 8'h10);
      pulse_cause(6'h02);
      rd(16'hFE01, 8'h08);
      pulse_cause(6'h01);
      rd(16'hFE01, 8'h02);
      wr(16'hFE04, 8'h02);
      rd(16'hFE04, 8'h02);
      chk({7'h0, watchdog_run}, 8'h00);
      wr(16'hFE04, 8'h00);
      rd(16'hFE04, 8'h00);
      chk({7'h0, watchdog_run}, 8'h01);
      rd(16'hFE00, 8'h00);
      wr(16'hFE03, 8'hFF);
      rd(16'hFE03, 8'h80);
      rd(16'hFE02, 8'h00);
      $display("test registers done");
    end
  endtask
  task t_irq;
    begin
      @(posedge clk);
      irq_enable <= 8'hDF;
      irq_req <= 8'h64;
      wait_take(12);
      chk(n[7:0], 8'h0C);
      core_op(4'h8);
      wait_take(12);
      chk_exc(4'h2, 1'b1);
      @(posedge clk);
      irq_req <= 8'h60;
      repeat (6) @(posedge clk);
      core_op(4'h8);
      wait_take(12);
      chk_exc(4'h6, 1'b1);
      @(posedge clk);
      irq_req <= 8'h00;
      $display("test interrupts done");
    end
  endtask
  task t_trap;
    begin
      repeat (6) @(posedge clk);
      core_op(4'h4);
      wait_take(8);
      chk_exc(4'hF, 1'b0);
      $display("test trap done");
    end
  endtask
  task t_wait;
    begin
      repeat (6) @(posedge clk);
      core_op(4'h2);
      repeat (3) @(posedge clk);
      #1;
      chk({4'h0, core_clk_en, periph_clk_en, watchdog_run, irq_mask}, 8'h06);
      @(posedge clk);
      irq_req <= 8'h08;
      wait_take(10);
      chk_exc(4'h3, 1'b1);
      chk({7'h0, n >= 3 && n <= 4}, 8'h01);
      @(posedge clk);
      irq_req <= 8'h00;
      $display("test wait done");
    end
  endtask
  task t_stop;
    begin
      wr(16'hFE04, 8'h01);
      repeat (6) @(posedge clk);
      core_op(4'h1);
      repeat (3) @(posedge clk);
      #1;
      chk({4'h0, crystal_clock_en, base_clock_out_en, periph_clk_en, core_clk_en}, 8'h00);
      @(posedge clk);
      break_req <= 1'b1;
      wait_take(200);
      chk_exc(4'hF, 1'b0);
      chk({7'h0, n >= 32 && n <= 40}, 8'h01);
      rd(16'hFE00, 8'h02);
      chk({6'h0, in_break, flag_clear_allow}, 8'h03);
      wr(16'hFE03, 8'h00);
      wr(16'hFE00, 8'h00);
      rd(16'hFE00, 8'h00);
      chk({6'h0, in_break, flag_clear_allow}, 8'h02);
      break_req <= 1'b0;
      $display("test stop done");
    end
  endtask
  task results;
    begin
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {reg_wr, reg_rd, return_from_interrupt_instruction, trap_exec, wait_exec, stop_exec, break_req, rst_cause_por, rst_cause_wdog} = 9'h000;
    {rst_cause_pin, rst_cause_ilop, rst_cause_ilad, rst_cause_lvi} = 4'h0;
    {reg_addr, reg_wdata, irq_req, irq_enable} = 40'h0;
    num_errors = 0;
    checked = 0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs;
    t_irq;
    t_trap;
    t_wait;
    t_stop;
    results;
  end
  initial begin
    #100000;
    num_errors = num_errors + 1;
    results;
  end
endmodule
